// File: testbench/slkek_engine_model.sv
// Behavioural crypto engine feeding result values to the key state block
`timescale 1ns/10ps
module slkek_engine_model (
  input  wire logic                        clk,
  output logic [slkek_pkg::KEY_W-1:0]      keyResult
);
  import slkek_pkg::*;
  // A fresh result every cycle, so a stale sample can never pass by luck
  always_ff @(posedge clk) begin
    for (int i = 0; i < KEY_W / 32; i++) begin
      keyResult[i*32 +: 32] <= $urandom;
    end
  end
endmodule

// File: testbench/slot_lock_and_ephemeral_key_state_test.sv
// Self-checking bench for the slot lock and ephemeral key state block
`timescale 1ns/10ps
module slot_lock_and_ephemeral_key_state_test;
  import slkek_pkg::*;
  typedef struct {logic [31:0] d; logic [31:0] m; logic [1:0] r;} slkek_exp_t;
  logic             clk = 1'b0;
  logic             rst = 1'b1;
  logic [7:0]       awAddr = '0, arAddr = '0;
  logic [31:0]      wData = '0;
  logic [3:0]       wStrb = 4'hF;
  logic             awValid = 1'b0, wValid = 1'b0, bReady = 1'b0, arValid = 1'b0, rReady = 1'b0;
  logic             awReady, wReady, bValid, arReady, rValid, keyUsable;
  logic [1:0]       bResp, rResp;
  logic [31:0]      rData;
  logic [KEY_W-1:0] keyResult, keyToEngine, snap, expKey;
  slkek_exp_t       q[$];
  int               failCount = 0;
  int               comparisons = 0;
  slkek_cmd_t       ops4[4] = '{CMD_WRITE, CMD_PRIVWR, CMD_KEYGEN, CMD_DERIVE};
  slkek_cmd_t       ops3[3] = '{CMD_NONCE, CMD_KEYGEN, CMD_DIGEST};

  always #5 clk = ~clk;

  slkek_engine_model engine (.clk(clk), .keyResult(keyResult));
  slkek_core DUT (
    .clk(clk), .rst(rst), .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
    .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(wStrb),
    .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp),
    .s_axi_bvalid(bValid), .s_axi_bready(bReady), .s_axi_araddr(arAddr),
    .s_axi_arvalid(arValid), .s_axi_arready(arReady), .s_axi_rdata(rData),
    .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
    .keyResult(keyResult), .keyToEngine(keyToEngine), .keyUsable(keyUsable)
  );

  task automatic chk(input string n, input logic [255:0] e, input logic [255:0] g);
    comparisons++;
    if (g !== e) begin
      failCount++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic giveVerdict;
    $display("Comparisons %0d, mismatches %0d", comparisons, failCount);
    if (failCount == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Response watcher: every handshake consumes the oldest expectation
  always @(posedge clk) begin
    slkek_exp_t x;
    if ((bValid && bReady) || (rValid && rReady)) begin
      if (q.size() == 0) begin
        chk("unexpected response", 1, 0);
      end else begin
        x = q.pop_front();
        if (bValid && bReady) begin
          chk("bresp", x.r, bResp);
        end else begin
          chk("rdata", x.d & x.m, rData & x.m);
          chk("rresp", x.r, rResp);
        end
      end
    end
  end

  // Address and data offered together; the key sample is taken at the edge acting on it
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    bit na, nw;
    q.push_back('{0, 0, r});
    @(posedge clk);
    awAddr <= a; wData <= d; awValid <= 1'b1; wValid <= 1'b1; bReady <= 1'b1;
    na = 0; nw = 0;
    do begin
      @(posedge clk);
      if (awValid && awReady) begin awValid <= 1'b0; na = 1; end
      if (wValid && wReady) begin wValid <= 1'b0; nw = 1; end
    end while (!(na && nw));
    @(posedge clk);
    snap = keyResult;
    while (!bValid) @(posedge clk);
    bReady <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m,
                    input logic [1:0] r);
    q.push_back('{d, m, r});
    @(posedge clk);
    arAddr <= a; arValid <= 1'b1; rReady <= 1'b1;
    do @(posedge clk); while (!arReady);
    arValid <= 1'b0;
    do @(posedge clk); while (!rValid);
    rReady <= 1'b0;
  endtask

  // Issue one command and check the outcome bit of the status word
  task automatic cmd(input slkek_cmd_t op, input logic [3:0] s, input slkek_zone_t z,
                     input slkek_err_t e, input logic [1:0] fl, input logic ok);
    axw(OFS_CMD, {10'h0, e, 2'h0, z, 2'h0, fl, s, 4'h0, op}, RESP_OKAY);
    rd(OFS_STATUS, {31'h0, ok}, 32'h1, RESP_OKAY);
  endtask

  task automatic vld(input logic b);
    rd(OFS_EPH_INFO, {23'h0, b, 8'h0}, 32'h100, RESP_OKAY);
    chk("keyUsable", b, keyUsable);
  endtask

  initial begin
    #100000;
    failCount++;
    giveVerdict();
  end

  initial begin
    logic [15:0] r16;
    void'($urandom(78));
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rd(OFS_LOCKS, 32'h5555, 32'h3FFFF, RESP_OKAY);
    rd(OFS_SLOT_LOCK, 32'hFFFF, 32'hFFFF, RESP_OKAY);
    rd(OFS_LOCKABLE, 32'h0, 32'hFFFF, RESP_OKAY);
    rd(OFS_EPH_INFO, 32'h0, 32'h1FF, RESP_OKAY);
    rd(8'h20, 32'h0, 32'hFFFFFFFF, RESP_SLVERR);
    axw(8'h20, 32'h0, RESP_SLVERR);
    cmd(CMD_READ, 4'h1, ZONE_DATA, ERR_NONE, 2'b00, 1'b0);
    cmd(CMD_WRITE, 4'h1, ZONE_DATA, ERR_NONE, 2'b00, 1'b0);
    cmd(CMD_WRITE, 4'h0, ZONE_OTP, ERR_NONE, 2'b00, 1'b0);
    r16 = 16'($urandom);
    axw(OFS_SLOT_LOCK, {16'h0, r16}, RESP_OKAY);
    rd(OFS_SLOT_LOCK, {16'h0, r16}, 32'hFFFF, RESP_OKAY);
    axw(OFS_SLOT_LOCK, 32'hFFFE, RESP_OKAY);
    axw(OFS_LOCKABLE, 32'h0002, RESP_OKAY);
    axw(OFS_MAC_FORBID, 32'h0004, RESP_OKAY);
    axw(OFS_LOCKS, 32'h5500, RESP_OKAY);
    rd(OFS_LOCKS, 32'h5500, 32'hFFFF, RESP_OKAY);
    axw(OFS_SLOT_LOCK, 32'hFFFF, RESP_OKAY);
    rd(OFS_SLOT_LOCK, 32'hFFFE, 32'hFFFF, RESP_OKAY);
    cmd(CMD_READ, 4'h1, ZONE_DATA, ERR_NONE, 2'b00, 1'b0);
    cmd(CMD_WRITE, 4'h1, ZONE_DATA, ERR_NONE, 2'b00, 1'b1);
    cmd(CMD_WRITE, 4'h0, ZONE_OTP, ERR_NONE, 2'b00, 1'b1);
    foreach (ops4[i]) cmd(ops4[i], 4'h0, ZONE_DATA, ERR_NONE, 2'b00, 1'b0);
    cmd(CMD_VERIFY, 4'h0, ZONE_DATA, ERR_NONE, 2'b00, 1'b1);
    cmd(CMD_LOCKSLOT, 4'h1, ZONE_DATA, ERR_NONE, 2'b00, 1'b1);
    cmd(CMD_LOCKSLOT, 4'h2, ZONE_DATA, ERR_NONE, 2'b00, 1'b0);
    rd(OFS_SLOT_LOCK, 32'hFFFC, 32'hFFFF, RESP_OKAY);
    cmd(CMD_WRITE, 4'h1, ZONE_DATA, ERR_NONE, 2'b00, 1'b0);
    cmd(CMD_WRITE, 4'h3, ZONE_DATA, ERR_NONE, 2'b00, 1'b1);
    axw(OFS_LOCKS, 32'h0, RESP_OKAY);
    rd(OFS_LOCKS, 32'h0, 32'hFFFF, RESP_OKAY);
    cmd(CMD_READ, 4'h3, ZONE_DATA, ERR_NONE, 2'b00, 1'b1);
    cmd(CMD_WRITE, 4'h3, ZONE_DATA, ERR_NONE, 2'b00, 1'b1);
    cmd(CMD_READ, 4'h0, ZONE_OTP, ERR_NONE, 2'b00, 1'b0);
    cmd(CMD_WRITE, 4'h0, ZONE_OTP, ERR_NONE, 2'b00, 1'b0);
    cmd(CMD_NONCE, 4'h0, ZONE_DATA, ERR_NONE, 2'b01, 1'b1);
    expKey = snap;
    rd(OFS_EPH_INFO, 32'h110, 32'h1FF, RESP_OKAY);
    chk("keyToEngine", expKey, keyToEngine);
    cmd(CMD_DIGEST, 4'h2, ZONE_DATA, ERR_NONE, 2'b00, 1'b1);
    expKey = expKey ^ snap;
    rd(OFS_EPH_INFO, 32'h1A2, 32'h1EF, RESP_OKAY);
    chk("keyToEngine", expKey, keyToEngine);
    cmd(CMD_MAC, 4'h0, ZONE_DATA, ERR_NONE, 2'b00, 1'b0);
    vld(1'b0);
    for (int o = 0; o < 3; o++) begin
      for (int e = 1; e < 4; e++) begin
        cmd(CMD_NONCE, 4'h0, ZONE_DATA, ERR_NONE, 2'b00, 1'b1);
        cmd(ops3[o], 4'h3, ZONE_DATA, slkek_err_t'(e), 2'b00, 1'b0);
        vld(e != 3);
      end
    end
    cmd(CMD_NONCE, 4'h0, ZONE_DATA, ERR_NONE, 2'b00, 1'b1);
    cmd(CMD_INFO, 4'h0, ZONE_DATA, ERR_NONE, 2'b00, 1'b1);
    vld(1'b1);
    cmd(CMD_SIGN, 4'h0, ZONE_DATA, ERR_CRC, 2'b00, 1'b0);
    vld(1'b1);
    cmd(CMD_SIGN, 4'h0, ZONE_DATA, ERR_NONE, 2'b00, 1'b1);
    vld(1'b0);
    cmd(CMD_MACCHK, 4'h0, ZONE_DATA, ERR_NONE, 2'b10, 1'b1);
    expKey = snap;
    vld(1'b1);
    cmd(CMD_MACCHK, 4'h0, ZONE_DATA, ERR_NONE, 2'b00, 1'b1);
    vld(1'b0);
    cmd(CMD_KEYGEN, 4'h3, ZONE_DATA, ERR_NONE, 2'b00, 1'b1);
    rd(OFS_EPH_INFO, 32'h143, 32'h1FF, RESP_OKAY);
    chk("keyToEngine", expKey ^ snap, keyToEngine);
    for (int b = 0; b < 4; b++) begin
      cmd(CMD_NONCE, 4'h0, ZONE_DATA, ERR_NONE, 2'b00, 1'b1);
      axw(OFS_POWER, 32'h1 << b, RESP_OKAY);
      vld(1'b0);
    end
    repeat (3) @(posedge clk);
    giveVerdict();
  end
endmodule

// File: verilog/slkek_core.sv
// Slot lock policy and ephemeral key state with an AXI4-Lite register port
// How it works
// - Data lock unlocked: refuse reads, allow writes
// - Data locked: access by policy, OTP mode
// - Sixteen slot-lock bits plus lockable flags
// - Config unlocked: lock bits freely writable
// - Lock bit zero blocks slot-modifying commands
// - Lock bit zero blocks writes, data unlocked
// - Lock and lockable bits select slot rights
// - Lockable slot may be locked once config is locked
// - Slot lock does no content checksum
// - Verify ignores the slot lock bit
// - Sleep or power loss invalidates key
// - Ephemeral key feeds listed commands internally
// - Ephemeral key value never leaves device
// - Info reports nine ephemeral status bits
// - Digest/keygen combine; nonce/copy replace key
// - Four-bit slot index records source slot
// - Randomness flag: 0 internal, 1 seed
// - Origin flags mark digest or keygen source
// - Mac-forbidden flag blocks MAC-type use
// - Valid cleared by power, sleep, faults
// - Nonce/keygen/digest clear valid on failures other than CRC/retry errors
// - Mac-check, info and others valid rules
// - No data/OTP access before config lock
`timescale 1ns/10ps
module slkek_core (
  input  wire logic                         clk,
  input  wire logic                         rst,
  input  wire logic [7:0]                   s_axi_awaddr,
  input  wire logic                         s_axi_awvalid,
  output logic                              s_axi_awready,
  input  wire logic [31:0]                  s_axi_wdata,
  input  wire logic [3:0]                   s_axi_wstrb,
  input  wire logic                         s_axi_wvalid,
  output logic                              s_axi_wready,
  output logic [1:0]                        s_axi_bresp,
  output logic                              s_axi_bvalid,
  input  wire logic                         s_axi_bready,
  input  wire logic [7:0]                   s_axi_araddr,
  input  wire logic                         s_axi_arvalid,
  output logic                              s_axi_arready,
  output logic [31:0]                       s_axi_rdata,
  output logic [1:0]                        s_axi_rresp,
  output logic                              s_axi_rvalid,
  input  wire logic                         s_axi_rready,
  input  wire logic [slkek_pkg::KEY_W-1:0]  keyResult,
  output logic [slkek_pkg::KEY_W-1:0]       keyToEngine,
  output logic                              keyUsable
);
  import slkek_pkg::*;
  default clocking cbAssert @(posedge clk);
  endclocking
  default disable iff (rst);

  logic [7:0]            configLock_reg;
  logic [7:0]            dataLock_reg;
  logic [1:0]            otpMode_reg;
  logic [15:0]           slotLock_reg;
  logic [15:0]           lockable_reg;
  logic [15:0]           macForbid_reg;
  logic [KEY_W-1:0]      ephKey_reg;
  logic [SLOT_IDX_W-1:0] ephSlot_reg;
  logic                  ephRand_reg;
  logic                  ephDigest_reg;
  logic                  ephKeygen_reg;
  logic                  ephNoMac_reg;
  logic                  ephValid_reg;
  logic                  cmdOk_reg;
  logic                  cmdDone_reg;
  logic                  awHeld_reg;
  logic [7:0]            awAddr_reg;
  logic                  wHeld_reg;
  logic [31:0]           wData_reg;
  logic [3:0]            wStrb_reg;

  logic                  configLocked;
  logic                  dataLocked;
  logic [15:0]           slotWritable;
  logic [15:0]           slotLockable;
  logic                  doWrite;
  logic [31:0]           wrData;
  logic                  fullWord;
  logic                  cmdStrobe;
  logic                  pwrStrobe;
  slkek_cmd_t            cmdOp;
  slkek_err_t            cmdErr;
  slkek_zone_t           cmdZone;
  logic [SLOT_IDX_W-1:0] cmdSlot;
  logic                  cmdAllowed;
  logic                  cmdSuccess;
  logic                  validClear;

  assign configLocked = (configLock_reg != UNLOCKED_VALUE);
  assign dataLocked   = (dataLock_reg != UNLOCKED_VALUE);

  // Per-slot rights derived from lock and lockable bits
  for (genvar gi = 0; gi < SLOT_COUNT; gi++) begin : gSlot
    assign slotWritable[gi] = slotLock_reg[gi];
    assign slotLockable[gi] = slotLock_reg[gi] & lockable_reg[gi];
  end

  // Write channel: address and data taken in either order, one at a time
  assign s_axi_awready = !awHeld_reg && !s_axi_bvalid;
  assign s_axi_wready  = !wHeld_reg && !s_axi_bvalid;
  assign doWrite       = awHeld_reg && wHeld_reg && !s_axi_bvalid;
  assign wrData        = wData_reg;
  assign fullWord      = (wStrb_reg == 4'hF);

  always_ff @(posedge clk) begin
    if (rst) begin
      awHeld_reg <= 1'b0;
      awAddr_reg <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      awHeld_reg <= 1'b1;
      awAddr_reg <= s_axi_awaddr;
    end else if (doWrite) begin
      awHeld_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wHeld_reg <= 1'b0;
      wData_reg <= 32'h0000_0000;
      wStrb_reg <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      wHeld_reg <= 1'b1;
      wData_reg <= s_axi_wdata;
      wStrb_reg <= s_axi_wstrb;
    end else if (doWrite) begin
      wHeld_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (doWrite) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (awAddr_reg[7:5] == 3'b000 && awAddr_reg[1:0] == 2'b00)
                      ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Commands and power events are taken only as whole-word writes
  assign cmdStrobe = doWrite && fullWord && (awAddr_reg == OFS_CMD);
  assign pwrStrobe = doWrite && fullWord && (awAddr_reg == OFS_POWER);
  assign cmdOp     = slkek_cmd_t'(wrData[CMD_OP_LSB +: 4]);
  assign cmdSlot   = wrData[CMD_SLOT_LSB +: SLOT_IDX_W];
  assign cmdZone   = slkek_zone_t'(wrData[CMD_ZONE_LSB +: 2]);
  assign cmdErr    = slkek_err_t'(wrData[CMD_ERR_LSB +: 2]);

  // Access policy for the command being reported
  always_comb begin
    cmdAllowed = 1'b1;
    unique case (cmdOp)
      CMD_READ: begin
        if (cmdZone != ZONE_CONFIG) begin
          cmdAllowed = configLocked && dataLocked;
          if (cmdZone == ZONE_OTP && otpMode_reg == 2'b00) begin
            cmdAllowed = 1'b0;
          end
        end
      end
      CMD_WRITE: begin
        if (cmdZone == ZONE_CONFIG) begin
          cmdAllowed = !configLocked;
        end else if (cmdZone == ZONE_OTP) begin
          cmdAllowed = configLocked && (!dataLocked || otpMode_reg == 2'b10);
        end else begin
          cmdAllowed = configLocked && slotWritable[cmdSlot];
        end
      end
      CMD_PRIVWR, CMD_KEYGEN, CMD_DERIVE: begin
        cmdAllowed = configLocked && slotWritable[cmdSlot];
      end
      CMD_LOCKSLOT: cmdAllowed = configLocked && slotLockable[cmdSlot];
      CMD_MAC, CMD_HMAC, CMD_SHAHMAC: cmdAllowed = ephValid_reg && !ephNoMac_reg;
      CMD_VERIFY: cmdAllowed = 1'b1;
      default: cmdAllowed = 1'b1;
    endcase
  end

  assign cmdSuccess = cmdAllowed && (cmdErr == ERR_NONE);

  // Valid-bit clearing per command outcome
  always_comb begin
    validClear = 1'b0;
    if (cmdStrobe) begin
      unique case (cmdOp)
        CMD_NONCE, CMD_KEYGEN, CMD_DIGEST: begin
          validClear = !cmdSuccess && cmdErr != ERR_CRC && cmdErr != ERR_RETRY;
        end
        CMD_MACCHK: validClear = !(cmdSuccess && wrData[CMD_COPY_BIT]);
        CMD_INFO: validClear = 1'b0;
        default: validClear = cmdErr != ERR_CRC && cmdErr != ERR_RETRY;
      endcase
    end
  end

  // Zone lock bytes and OTP mode
  always_ff @(posedge clk) begin
    if (rst) begin
      configLock_reg <= LOCK_RESET;
      dataLock_reg   <= LOCK_RESET;
      otpMode_reg    <= 2'b00;
    end else if (doWrite && awAddr_reg == OFS_LOCKS) begin
      // Lock bytes only move away from the unlocked value, never back
      if (wStrb_reg[0] && !configLocked) begin
        configLock_reg <= wrData[7:0];
      end
      if (wStrb_reg[1] && configLocked && !dataLocked) begin
        dataLock_reg <= wrData[15:8];
      end
      if (wStrb_reg[2] && !configLocked) begin
        otpMode_reg <= wrData[17:16];
      end
    end
  end

  // Slot lock, lockable and mac-forbidden bits
  always_ff @(posedge clk) begin
    if (rst) begin
      slotLock_reg  <= SLOT_LOCK_RESET;
      lockable_reg  <= LOCKABLE_RESET;
      macForbid_reg <= MAC_FORBID_RESET;
    end else if (cmdStrobe && cmdOp == CMD_LOCKSLOT && cmdSuccess) begin
      slotLock_reg[cmdSlot] <= 1'b0;
    end else if (doWrite && !configLocked && wStrb_reg[1:0] == 2'b11) begin
      if (awAddr_reg == OFS_SLOT_LOCK) begin
        slotLock_reg <= wrData[15:0];
      end
      if (awAddr_reg == OFS_LOCKABLE) begin
        lockable_reg <= wrData[15:0];
      end
      if (awAddr_reg == OFS_MAC_FORBID) begin
        macForbid_reg <= wrData[15:0];
      end
    end
  end

  // Ephemeral key contents and its flags
  always_ff @(posedge clk) begin
    if (rst) begin
      ephKey_reg    <= '0;
      ephSlot_reg   <= '0;
      ephRand_reg   <= 1'b0;
      ephDigest_reg <= 1'b0;
      ephKeygen_reg <= 1'b0;
      ephNoMac_reg  <= 1'b0;
    end else if (cmdStrobe && cmdSuccess) begin
      unique case (cmdOp)
        CMD_DIGEST, CMD_KEYGEN: begin
          ephKey_reg    <= keyResult ^ ephKey_reg;
          ephSlot_reg   <= cmdSlot;
          ephDigest_reg <= (cmdOp == CMD_DIGEST);
          ephKeygen_reg <= (cmdOp == CMD_KEYGEN);
          ephNoMac_reg  <= ephNoMac_reg | macForbid_reg[cmdSlot];
        end
        CMD_NONCE: begin
          ephKey_reg    <= keyResult;
          ephRand_reg   <= wrData[CMD_RAND_BIT];
          ephDigest_reg <= 1'b0;
          ephKeygen_reg <= 1'b0;
          ephNoMac_reg  <= 1'b0;
        end
        CMD_MACCHK: begin
          if (wrData[CMD_COPY_BIT]) begin
            ephKey_reg    <= keyResult;
            ephDigest_reg <= 1'b0;
            ephKeygen_reg <= 1'b0;
            ephNoMac_reg  <= macForbid_reg[cmdSlot];
          end
        end
        default: ephKey_reg <= ephKey_reg;
      endcase
    end
  end

  // Power events win over command setting of the valid bit
  always_ff @(posedge clk) begin
    if (rst) begin
      ephValid_reg <= 1'b0;
    end else if (pwrStrobe && wrData[3:0] != 4'h0) begin
      ephValid_reg <= 1'b0;
    end else if (validClear) begin
      ephValid_reg <= 1'b0;
    end else if (cmdStrobe && cmdSuccess &&
                 (cmdOp == CMD_NONCE || cmdOp == CMD_DIGEST || cmdOp == CMD_KEYGEN ||
                  (cmdOp == CMD_MACCHK && wrData[CMD_COPY_BIT]))) begin
      ephValid_reg <= 1'b1;
    end
  end

  // Last command outcome, readable by software
  always_ff @(posedge clk) begin
    if (rst) begin
      cmdOk_reg   <= 1'b0;
      cmdDone_reg <= 1'b0;
    end else if (cmdStrobe) begin
      cmdOk_reg   <= cmdSuccess;
      cmdDone_reg <= 1'b1;
    end
  end

  // Key used only internally; the bus never sees it
  assign keyToEngine = ephKey_reg;
  assign keyUsable   = ephValid_reg;

  // Read channel
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge clk) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= RESP_OKAY;
      unique case (s_axi_araddr)
        OFS_LOCKS:      s_axi_rdata <= {14'h0000, otpMode_reg, dataLock_reg, configLock_reg};
        OFS_SLOT_LOCK:  s_axi_rdata <= {16'h0000, slotLock_reg};
        OFS_LOCKABLE:   s_axi_rdata <= {16'h0000, lockable_reg};
        OFS_MAC_FORBID: s_axi_rdata <= {16'h0000, macForbid_reg};
        OFS_CMD:        s_axi_rdata <= 32'h0000_0000;
        OFS_STATUS:     s_axi_rdata <= {28'h0000000, configLocked, dataLocked,
                                        cmdDone_reg, cmdOk_reg};
        OFS_EPH_INFO:   s_axi_rdata <= {23'h000000, ephValid_reg, ephNoMac_reg,
                                        ephKeygen_reg, ephDigest_reg, ephRand_reg,
                                        ephSlot_reg};
        OFS_POWER:      s_axi_rdata <= 32'h0000_0000;
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  property p_data_read_refused;
    (cmdStrobe && cmdOp == CMD_READ && cmdZone == ZONE_DATA && !dataLocked) |=> !cmdOk_reg;
  endproperty
  a_data_read_refused: assert property (p_data_read_refused) else $error("unlocked read");
  property p_locked_slot_refuses;
    (cmdStrobe && (cmdOp == CMD_WRITE || cmdOp == CMD_KEYGEN) && cmdZone == ZONE_DATA
     && !slotLock_reg[cmdSlot]) |=> !cmdOk_reg;
  endproperty
  a_locked_slot_refuses: assert property (p_locked_slot_refuses) else $error("bad write");
  property p_lock_clears_bit;
    (cmdStrobe && cmdOp == CMD_LOCKSLOT && cmdSuccess) |=> !slotLock_reg[$past(cmdSlot)];
  endproperty
  a_lock_clears_bit: assert property (p_lock_clears_bit) else $error("slot not locked");
  property p_no_access_before_config;
    (cmdStrobe && cmdZone != ZONE_CONFIG && (cmdOp == CMD_READ || cmdOp == CMD_WRITE)
     && !configLocked) |=> !cmdOk_reg;
  endproperty
  a_no_access_before_config: assert property (p_no_access_before_config)
    else $error("early access");
  property p_power_clears_valid;
    (pwrStrobe && wrData[3:0] != 4'h0) |=> !ephValid_reg;
  endproperty
  a_power_clears_valid: assert property (p_power_clears_valid) else $error("valid kept");
  property p_info_keeps_valid;
    (cmdStrobe && cmdOp == CMD_INFO && !pwrStrobe) |=> ephValid_reg == $past(ephValid_reg);
  endproperty
  a_info_keeps_valid: assert property (p_info_keeps_valid) else $error("valid changed");
  property p_retry_keeps_valid;
    (cmdStrobe && cmdOp == CMD_NONCE && cmdErr == ERR_RETRY) |=> $stable(ephValid_reg);
  endproperty
  a_retry_keeps_valid: assert property (p_retry_keeps_valid) else $error("retry cleared");
  property p_mac_forbidden_slot_bit_blocks;
    (cmdStrobe && cmdOp == CMD_MAC && ephNoMac_reg) |=> !cmdOk_reg;
  endproperty
  a_mac_forbidden_slot_bit_blocks: assert property (p_mac_forbidden_slot_bit_blocks) else $error("mac allowed");
  property p_digest_flags;
    (cmdStrobe && cmdOp == CMD_DIGEST && cmdSuccess) |=>
      ephDigest_reg && !ephKeygen_reg && ephSlot_reg == $past(cmdSlot);
  endproperty
  a_digest_flags: assert property (p_digest_flags) else $error("digest flags wrong");

endmodule

// File: verilog/slkek_pkg.sv
// Shared constants and types for the slot lock and ephemeral key state block
package slkek_pkg;

  localparam logic [7:0]  UNLOCKED_VALUE   = 8'h55;
  localparam int          SLOT_COUNT       = 16;
  localparam int          SLOT_IDX_W       = 4;
  localparam int          KEY_W            = 256;

  // Register byte offsets on the AXI4-Lite bus
  localparam logic [7:0]  OFS_LOCKS        = 8'h00;
  localparam logic [7:0]  OFS_SLOT_LOCK    = 8'h04;
  localparam logic [7:0]  OFS_LOCKABLE     = 8'h08;
  localparam logic [7:0]  OFS_MAC_FORBID   = 8'h0C;
  localparam logic [7:0]  OFS_CMD          = 8'h10;
  localparam logic [7:0]  OFS_STATUS       = 8'h14;
  localparam logic [7:0]  OFS_EPH_INFO     = 8'h18;
  localparam logic [7:0]  OFS_POWER        = 8'h1C;

  // Reset values
  localparam logic [7:0]  LOCK_RESET       = 8'h55;
  localparam logic [15:0] SLOT_LOCK_RESET  = 16'hFFFF;
  localparam logic [15:0] LOCKABLE_RESET   = 16'h0000;
  localparam logic [15:0] MAC_FORBID_RESET = 16'h0000;

  // Command field positions in OFS_CMD write
  localparam int          CMD_OP_LSB       = 0;
  localparam int          CMD_SLOT_LSB     = 8;
  localparam int          CMD_RAND_BIT     = 12;
  localparam int          CMD_COPY_BIT     = 13;
  localparam int          CMD_ZONE_LSB     = 16;
  localparam int          CMD_ERR_LSB      = 20;

  // Power event bit positions in OFS_POWER write
  localparam int          PWR_SLEEP_BIT    = 0;
  localparam int          PWR_BROWN_BIT    = 1;
  localparam int          PWR_WDOG_BIT     = 2;
  localparam int          PWR_TAMPER_BIT   = 3;

  // AXI responses
  localparam logic [1:0]  RESP_OKAY        = 2'b00;
  localparam logic [1:0]  RESP_SLVERR      = 2'b10;

  typedef enum logic [3:0] {
    CMD_NONE     = 4'h0,
    CMD_READ     = 4'h1,
    CMD_WRITE    = 4'h2,
    CMD_PRIVWR   = 4'h3,
    CMD_KEYGEN   = 4'h4,
    CMD_DERIVE   = 4'h5,
    CMD_DIGEST   = 4'h6,
    CMD_NONCE    = 4'h7,
    CMD_MACCHK   = 4'h8,
    CMD_INFO     = 4'h9,
    CMD_MAC      = 4'hA,
    CMD_HMAC     = 4'hB,
    CMD_SIGN     = 4'hC,
    CMD_VERIFY   = 4'hD,
    CMD_LOCKSLOT = 4'hE,
    CMD_SHAHMAC  = 4'hF
  } slkek_cmd_t;

  typedef enum logic [1:0] {
    ERR_NONE  = 2'h0,
    ERR_CRC   = 2'h1,
    ERR_RETRY = 2'h2,
    ERR_OTHER = 2'h3
  } slkek_err_t;

  typedef enum logic [1:0] {
    ZONE_CONFIG = 2'h0,
    ZONE_DATA   = 2'h1,
    ZONE_OTP    = 2'h2
  } slkek_zone_t;

endpackage
